// File: hcp_host.sv
// host model: sends command bytes and collects output characters
`timescale 1ns/10ps
`default_nettype none
module hcp_host (
   input wire logic aclk,
   input wire logic in_ready,
   output logic in_valid,
   output logic [7:0] in_byte,
   input wire logic [1:0] tx_valid,
   input wire logic [1:0][7:0] tx_data,
   output logic [1:0] tx_ready
);
   logic [7:0] q [$];
   logic [7:0] rx0 [$];
   logic [7:0] rx1 [$];
   logic slow = 1'b0;
   logic [1:0] tick = 2'h0;
   initial begin
      in_valid = 1'b0;
      in_byte = 8'h00;
      tx_ready = 2'b11;
   end
   always @(posedge aclk) begin
      tick <= tick + 2'h1;
      // a slow host stalls both links in a rolling pattern
      tx_ready <= slow ? tick : 2'b11;
      if (tx_valid[0] && tx_ready[0]) rx0.push_back(tx_data[0]);
      if (tx_valid[1] && tx_ready[1]) rx1.push_back(tx_data[1]);
      // byte held until taken; idle line inverts itself every cycle, toggling between the last byte and its inverse
      if (!in_valid || in_ready) begin
         in_valid <= (q.size() > 0);
         in_byte <= (q.size() > 0) ? q.pop_front() : ~in_byte;
      end
   end
endmodule : hcp_host
`default_nettype wire

// File: hcp_parser_outq.sv
// host command parser with per-port output queues and AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hcp_parser_outq
   import hcp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire hcp_axi_req_t s_axi_req,
   output hcp_axi_rsp_t s_axi_rsp,
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   input wire logic in_port,
   input wire logic in_from_prog,
   output logic in_ready,
   input wire logic msg_valid,
   input wire logic [7:0] msg_byte,
   input wire logic msg_port_given,
   input wire logic msg_port,
   output logic msg_ready,
   input wire logic iface_switch,
   input wire logic [1:0] tx_ready,
   output logic [1:0] tx_valid,
   output logic [1:0][7:0] tx_data,
   output logic cmd_pulse,
   output hcp_cmd_t cmd_info
);
   hcp_state_t st;
   hcp_state_t n;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic is_upper(input logic [7:0] c);
      return (c >= CH_A) && (c <= CH_Z);
   endfunction : is_upper

   function automatic logic [3:0] axis_of(input logic [7:0] c);
      logic [3:0] r;
      r = 4'h0;
      if (c == CH_X) r = 4'h8;
      else if (c == CH_Y) r = 4'h9;
      else if (c == CH_Z) r = 4'hA;
      else if (c == CH_W) r = 4'hB;
      else if (AXIS_COUNT >= MIN_LETTER_AXES && c >= CH_A && c <= CH_H) r = {1'b1, 3'(c - CH_A)};
      return r;
   endfunction : axis_of

   function automatic logic [2:0] low_bit(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) r = 3'(i);
      end
      return r;
   endfunction : low_bit

   function automatic logic [7:0] fifo_depth(input logic p);
      return p ? RS_DEPTH : USB_DEPTH;
   endfunction : fifo_depth

   function automatic logic [7:0] wrap(input logic p, input logic [8:0] s);
      logic [8:0] d;
      d = {1'b0, fifo_depth(p)};
      return (s >= d) ? 8'(s - d) : s[7:0];
   endfunction : wrap

   function automatic logic [31:0] bin_value(input logic [47:0] a, input logic [7:0] size);
      logic [31:0] r;
      r = a[47:16];
      if (size == SIZE_1) r = {{24{a[7]}}, a[7:0]};
      else if (size == SIZE_2) r = {{16{a[15]}}, a[15:0]};
      else if (size == SIZE_4) r = a[31:0];
      return r;
   endfunction : bin_value

   function automatic hcp_state_t close_field(input hcp_state_t s);
      hcp_state_t r;
      logic [31:0] v;
      r = s;
      v = s.fneg ? -s.acc[31:0] : s.acc[31:0];
      if (s.fquery) begin
         r.work.query_mask[s.fidx] = 1'b1;
      end else if (s.fhas && s.op == OUTFMT_OP) begin
         if (s.fidx == 3'h0 && v == FMT_MARK_ON) r.ctrl.mark = 1'b1;
         else if (s.fidx == 3'h0 && v == FMT_MARK_OFF) r.ctrl.mark = 1'b0;
         else if (s.fidx == 3'h1) r.ctrl.drop = v[0];
      end else if (s.fhas) begin
         r.axis_val[s.fidx] = v;
         r.work.set_mask[s.fidx] = 1'b1;
      end
      r.fhas = 1'b0;
      r.fquery = 1'b0;
      r.fneg = 1'b0;
      r.acc = '0;
      return r;
   endfunction : close_field

   function automatic hcp_state_t finish(input hcp_state_t s);
      hcp_state_t r;
      r = s;
      r.work.opcode = s.op;
      r.work.valid = !s.bad;
      if (!s.work.binary && !s.had_arg) r.work.act_mask = AXES_ALL;
      r.cmd = r.work;
      r.cmd_pulse = 1'b1;
      r.cmd_count = s.cmd_count + 32'h00000001;
      r.resp_pend = 1'b1;
      r.resp_char = s.bad ? CH_QUERY : CH_COLON;
      r.resp_port = s.work.port;
      r.ps = PS_IDLE;
      return r;
   endfunction : finish

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic take;
      logic term;
      logic [3:0] ax;
      logic [7:0] dig;
      logic [7:0] rem;
      logic [47:0] nacc;
      logic [31:0] rd_word;
      logic hit;
      logic gen;
      logic push;
      logic [7:0] pchar;
      logic pport;
      logic [1:0] pop;
      logic anyfull;
      take = in_valid && st.in_ready;
      term = (in_byte == CH_SEMI) || (in_byte == CH_CR);
      ax = axis_of(in_byte);
      dig = 8'(in_byte - CH_ZERO);
      rem = st.brem;
      nacc = {st.acc[39:0], in_byte};
      rd_word = '0;
      hit = 1'b1;
      gen = 1'b0;
      push = 1'b0;
      pchar = '0;
      pport = 1'b0;
      pop = '0;
      n = st;
      n.cmd_pulse = 1'b0;
      // switch sampling: third stage only compared with second
      n.sync = {st.sync[1:0], iface_switch};
      if (st.warm != SYNC_WARM) n.warm = 2'(st.warm + 2'h1);
      if (!st.caught && st.warm == SYNC_WARM && st.sync[1] == st.sync[2]) begin
         n.default_port = st.sync[2];
         n.caught = 1'b1;
      end
      // register writes
      if (s_axi_req.awvalid && st.rsp.awready) begin
         n.aw_held = 1'b1;
         n.aw_addr = s_axi_req.awaddr;
      end
      if (s_axi_req.wvalid && st.rsp.wready) begin
         n.w_held = 1'b1;
         n.wdata = s_axi_req.wdata;
         n.wstrb = s_axi_req.wstrb;
      end
      if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.rsp.bvalid = 1'b1;
         n.rsp.bresp = RESP_OKAY;
         unique case ({st.aw_addr[7:2], 2'b00})
            REG_CTRL: if (st.wstrb[0]) n.ctrl = st.wdata[2:0];
            REG_VAL_SEL: if (st.wstrb[0]) n.sel = st.wdata[2:0];
            REG_STATUS, REG_LAST_CMD, REG_AXIS_MASKS, REG_VAL, REG_CMD_COUNT: ;
            default: n.rsp.bresp = RESP_SLVERR;
         endcase
      end else if (st.rsp.bvalid && s_axi_req.bready) begin
         n.rsp.bvalid = 1'b0;
      end
      // register reads
      unique case ({s_axi_req.araddr[7:2], 2'b00})
         REG_CTRL: rd_word = {29'h0, st.ctrl};
         REG_STATUS: rd_word = {8'h00, st.cnt[1], st.cnt[0], 4'h0, st.ps != PS_IDLE,
            st.cnt[1] == RS_DEPTH, st.cnt[0] == USB_DEPTH, st.default_port};
         REG_LAST_CMD: rd_word = {4'h0, st.cmd.size[3:0], 2'h0, st.cmd.planes, st.cmd.port,
            st.cmd.from_prog, st.cmd.binary, st.cmd.valid, st.cmd.opcode};
         REG_AXIS_MASKS: rd_word = {8'h00, st.cmd.act_mask, st.cmd.query_mask, st.cmd.set_mask};
         REG_VAL_SEL: rd_word = {29'h0, st.sel};
         REG_VAL: rd_word = st.axis_val[st.sel];
         REG_CMD_COUNT: rd_word = st.cmd_count;
         default: hit = 1'b0;
      endcase
      if (s_axi_req.arvalid && st.rsp.arready) begin
         n.rsp.rvalid = 1'b1;
         n.rsp.rdata = rd_word;
         n.rsp.rresp = hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st.rsp.rvalid && s_axi_req.rready) begin
         n.rsp.rvalid = 1'b0;
      end
      // command parser
      if (take) begin
         unique case (st.ps)
            PS_IDLE: if (!term) begin
               n.work = '0;
               n.work.port = in_port;
               n.work.from_prog = in_from_prog;
               n.work.binary = in_byte >= BIN_FIRST;
               n.bad = 1'b0;
               n.had_arg = 1'b0;
               n.space_used = 1'b0;
               n.last_letter = 1'b0;
               n.fidx = 3'h0;
               n.fhas = 1'b0;
               n.fquery = 1'b0;
               n.fneg = 1'b0;
               n.acc = '0;
               if (in_byte >= BIN_FIRST && in_from_prog) begin
                  n.bad = 1'b1;
                  n.ps = PS_SKIP;
               end else if (in_byte >= BIN_FIRST) begin
                  n.op = {8'h00, in_byte};
                  n.ps = PS_BSIZE;
               end else begin
                  n.op = {in_byte, 8'h00};
                  n.bad = !is_upper(in_byte);
                  n.ps = PS_OP2;
               end
            end
            PS_OP2: begin
               if (term) begin
                  n.bad = 1'b1;
                  n = finish(n);
               end else begin
                  n.op[7:0] = in_byte;
                  n.bad = st.bad || !is_upper(in_byte);
                  n.ps = PS_ARGS;
               end
            end
            PS_ARGS: begin
               if (term) begin
                  n = finish(close_field(n));
               end else if (in_byte == CH_SPACE && !st.space_used && !st.had_arg) begin
                  n.space_used = 1'b1;
               end else begin
                  n.had_arg = 1'b1;
                  if (in_byte >= CH_ZERO && in_byte <= CH_NINE) begin
                     n.acc = 48'(st.acc * DEC_BASE) + {40'h0, dig};
                     n.fhas = 1'b1;
                  end else if (in_byte == CH_MINUS && !st.fhas) begin
                     n.fneg = 1'b1;
                  end else if (in_byte == CH_QUERY) begin
                     n.fquery = 1'b1;
                  end else if (in_byte == CH_COMMA) begin
                     n = close_field(n);
                     n.fidx = 3'(st.fidx + 3'h1);
                     n.bad = st.bad || (st.fidx == 3'h7);
                  end else if (in_byte == CH_EQ && st.last_letter) begin
                     n.fidx = st.last_axis;
                     n.work.act_mask[st.last_axis] = 1'b0;
                     n.last_letter = 1'b0;
                  end else if (ax[3]) begin
                     n.work.act_mask[ax[2:0]] = 1'b1;
                     n.last_axis = ax[2:0];
                     n.last_letter = 1'b1;
                  end else if (in_byte == CH_S || in_byte == CH_T) begin
                     n.work.planes[in_byte == CH_T] = 1'b1;
                  end else begin
                     n.bad = 1'b1;
                  end
               end
            end
            PS_SKIP: if (term) n = finish(n);
            PS_BSIZE: begin
               n.bsize = in_byte;
               n.work.size = in_byte;
               n.bad = !(in_byte == SIZE_0 || in_byte == SIZE_1 || in_byte == SIZE_2 ||
                  in_byte == SIZE_4 || in_byte == SIZE_6);
               n.ps = PS_BCOORD;
            end
            PS_BCOORD: begin
               n.work.planes[0] = in_byte == COORD_ON;
               n.ps = PS_BMASK;
            end
            PS_BMASK: begin
               n.work.act_mask = in_byte;
               n.brem = in_byte;
               n.fidx = low_bit(in_byte);
               n.bcnt = 3'h0;
               n.acc = '0;
               if (st.bad || st.bsize == SIZE_0 || in_byte == 8'h00) n = finish(n);
               else n.ps = PS_BDATA;
            end
            PS_BDATA: begin
               n.acc = nacc;
               n.bcnt = 3'(st.bcnt + 3'h1);
               if (3'(st.bcnt + 3'h1) == st.bsize[2:0]) begin
                  n.axis_val[st.fidx] = bin_value(nacc, st.bsize);
                  n.work.set_mask[st.fidx] = 1'b1;
                  rem[st.fidx] = 1'b0;
                  n.brem = rem;
                  n.fidx = low_bit(rem);
                  n.bcnt = 3'h0;
                  n.acc = '0;
                  if (rem == 8'h00) n = finish(n);
               end
            end
         endcase
      end
      // transmit stage per port: holds data until the link takes it
      for (int p = 0; p < 2; p++) begin
         if (!st.tx_valid[p] || tx_ready[p] || !st.ctrl.hs_en) begin
            n.tx_valid[p] = st.cnt[p] != 8'h00;
            if (st.cnt[p] != 8'h00) begin
               n.tx_data[p] = st.mem[p][st.rd[p][6:0]];
               n.rd[p] = wrap(1'(p), {1'b0, st.rd[p]} + 9'h001);
               pop[p] = 1'b1;
            end
         end
      end
      // output generation: command answers win over unsolicited messages
      if (st.resp_pend) begin
         gen = 1'b1;
         pchar = st.resp_char;
         pport = st.resp_port;
      end else if (msg_valid && st.msg_ready) begin
         gen = 1'b1;
         pchar = msg_byte | (st.ctrl.mark ? MARK_BIT : 8'h00);
         pport = msg_port_given ? msg_port : st.default_port;
         n.last_gen = pchar;
         n.last_gen_port = pport;
      end
      push = gen && (st.cnt[pport] != fifo_depth(pport));
      if (st.resp_pend && (push || st.ctrl.drop)) n.resp_pend = 1'b0;
      if (push) n.mem[pport][wrap(pport, {1'b0, st.rd[pport]} + {1'b0, st.cnt[pport]})] = pchar;
      for (int p = 0; p < 2; p++) begin
         n.cnt[p] = 8'(st.cnt[p] + {7'h00, push && pport == 1'(p)} - {7'h00, pop[p]});
      end
      anyfull = (n.cnt[0] == USB_DEPTH) || (n.cnt[1] == RS_DEPTH);
      n.in_ready = !n.resp_pend && (n.ctrl.drop || !anyfull);
      n.msg_ready = !n.resp_pend && (n.ctrl.drop || !anyfull);
      n.rsp.awready = !n.aw_held;
      n.rsp.wready = !n.w_held;
      n.rsp.arready = !n.rsp.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ctrl <= CTRL_RESET;
      end else begin
         st <= n;
      end
   end

   assign s_axi_rsp = st.rsp;
   assign in_ready = st.in_ready;
   assign msg_ready = st.msg_ready;
   assign tx_valid = st.tx_valid;
   assign tx_data = st.tx_data;
   assign cmd_pulse = st.cmd_pulse;
   assign cmd_info = st.cmd;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic any_full;
   assign any_full = (st.cnt[0] == USB_DEPTH) || (st.cnt[1] == RS_DEPTH);

   sequence s_hold_full;
      (!st.ctrl.drop && any_full) [*2];
   endsequence
   sequence s_msg_default;
      msg_valid && st.msg_ready && !msg_port_given;
   endsequence
   sequence s_tx_stalled;
      st.tx_valid[0] && !tx_ready[0] && st.ctrl.hs_en;
   endsequence

   AST_USB_BOUND: assert property (st.cnt[0] <= USB_DEPTH)
      else $error("usb queue count above depth");
   AST_RS_BOUND: assert property (st.cnt[1] <= RS_DEPTH)
      else $error("serial queue count above depth");
   AST_SUSPEND: assert property (s_hold_full |-> !st.in_ready && !st.msg_ready)
      else $error("commands accepted while queue full under hold policy");
   AST_DISCARD: assert property ((st.ctrl.drop && !st.resp_pend) |-> st.msg_ready)
      else $error("message input stalled under discard policy");
   AST_DEFAULT_ROUTE: assert property (s_msg_default |=> st.last_gen_port == $past(st.default_port))
      else $error("unaddressed message not sent to default port");
   AST_MARK: assert property ((msg_valid && st.msg_ready && st.ctrl.mark) |=> st.last_gen[7])
      else $error("unsolicited character not marked");
   AST_ANSWER: assert property (st.cmd_pulse |-> st.resp_pend && st.resp_port == st.cmd.port
      && st.resp_char == (st.cmd.valid ? CH_COLON : CH_QUERY))
      else $error("answer character or port wrong");
   AST_NO_PROG_BIN: assert property ((st.cmd_pulse && st.cmd.binary) |-> !st.cmd.valid
      || !st.cmd.from_prog)
      else $error("binary command accepted from program");
   AST_BIN_RANGE: assert property ((st.cmd_pulse && st.cmd.binary) |-> st.cmd.opcode[7])
      else $error("binary opcode below range");
   AST_UPPER: assert property ((st.cmd_pulse && st.cmd.valid && !st.cmd.binary) |->
      is_upper(st.cmd.opcode[15:8]) && is_upper(st.cmd.opcode[7:0]))
      else $error("lower case opcode accepted");
   AST_TX_HOLD: assert property (s_tx_stalled |=> st.tx_valid[0] && $stable(st.tx_data[0]))
      else $error("usb output changed before taken");
   AST_SWITCH_HELD: assert property ($past(st.caught) |-> $stable(st.default_port))
      else $error("default port changed after capture");
endmodule : hcp_parser_outq
`default_nettype wire

// File: hcp_parser_outq_tb.sv
// self-checking bench of the host command parser with output queues
`timescale 1ns/10ps
`default_nettype none
module hcp_parser_outq_tb
   import hcp_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   hcp_axi_req_t req = '0;
   hcp_axi_rsp_t rsp;
   logic in_valid, in_ready, msg_ready, cmd_pulse;
   logic [7:0] in_byte;
   logic msg_valid = 1'b0;
   logic [7:0] msg_byte = 8'h00;
   logic msg_port_given = 1'b0;
   logic msg_port = 1'b0;
   logic [1:0] tx_ready, tx_valid;
   logic [1:0][7:0] tx_data;
   hcp_cmd_t cmd_info;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int pulses = 0;
   logic [31:0] d;
   logic [1:0] r;
   string cs [8] = '{"PR 5;", "PR,?;", "BG YW;", "BG;", "BG AH;", "PRZ=3;", "BG SY;", "bg;"};
   logic [23:0] mk [8] = '{24'h000001, 24'h000200, 24'h0A0000, 24'hFF0000, 24'h810000,
      24'h000004, 24'h020000, 24'h000000};
   logic [7:0] bin [12] = '{8'hA7, 8'h02, 8'h00, 8'h05, 8'h03, 8'hE8, 8'hFE, 8'h0C,
      8'hA1, 8'h00, 8'h01, 8'h07};
   hcp_parser_outq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
      .in_valid(in_valid), .in_byte(in_byte), .in_port(1'b0), .in_from_prog(1'b0),
      .in_ready(in_ready), .msg_valid(msg_valid), .msg_byte(msg_byte),
      .msg_port_given(msg_port_given), .msg_port(msg_port), .msg_ready(msg_ready),
      .iface_switch(1'b0), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .cmd_pulse(cmd_pulse), .cmd_info(cmd_info));
   hcp_host host (.aclk(aclk), .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   initial forever #50 aclk = ~aclk;
   //////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (mismatches == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do @(posedge aclk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge aclk); while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask : axr
   task automatic val(input logic [2:0] a, input logic [31:0] e);
      axw(REG_VAL_SEL, {29'h0, a});
      axr(REG_VAL);
      chk(d, e);
   endtask : val
   task automatic resp(input logic [7:0] e);
      while (host.rx0.size() == 0) @(posedge aclk);
      chk(host.rx0.pop_front(), e);
   endtask : resp
   task automatic cmd(input string s, input logic [7:0] e);
      for (int k = 0; k < s.len(); k++) host.q.push_back(s[k]);
      resp(e);
   endtask : cmd
   task automatic msg(input logic g, input logic [7:0] e);
      msg_valid <= 1'b1;
      msg_byte <= 8'h41;
      msg_port_given <= g;
      msg_port <= g;
      do @(posedge aclk); while (msg_ready !== 1'b1);
      msg_valid <= 1'b0;
      while (g && host.rx1.size() == 0) @(posedge aclk);
      if (g) chk(host.rx1.pop_front(), e);
      else resp(e);
   endtask : msg
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cmd_pulse === 1'b1) pulses <= pulses + 1;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // default port needs the switch synchroniser to settle
      repeat (8) @(posedge aclk);
      axr(REG_CTRL);
      chk(d, 32'h4);
      axr(REG_STATUS);
      chk(d[0], PORT_USB);
      axr(8'h40);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(d, 32'h00000000);
      foreach (cs[i]) begin
         cmd(cs[i], (i == 7) ? CH_QUERY : CH_COLON);
         axr(REG_AXIS_MASKS);
         if (i != 7) chk(d, {8'h00, mk[i]});
      end
      cmd("PR 5,6;", CH_COLON);
      cmd("PR,,7;", CH_COLON);
      for (int a = 0; a < 3; a++) val(3'(a), 32'h5 + 32'(a));
      host.slow = 1'b1;
      foreach (bin[i]) host.q.push_back(bin[i]);
      resp(CH_COLON);
      resp(CH_COLON);
      axr(REG_LAST_CMD);
      chk(d & 32'h003300FF, 32'h001300A1);
      chk({16'h0000, cmd_info.opcode}, 32'h000000A1);
      val(3'h0, 32'h000003E8);
      val(3'h2, 32'hFFFFFE0C);
      cmd("CW1;", CH_COLON);
      msg(1'b0, 8'hC1);
      msg(1'b1, 8'hC1);
      cmd("CW2;", CH_COLON);
      msg(1'b0, 8'h41);
      axr(REG_CMD_COUNT);
      chk(d, 32'h0000000E);
      chk(32'(pulses), 32'h0000000E);
      test_done();
   end
endmodule : hcp_parser_outq_tb
`default_nettype wire

// File: hcp_pkg.sv
// package: constants and types of the host command parser with output queue
`default_nettype none
package hcp_pkg;
   localparam int AXIS_COUNT = 8;
   localparam int MIN_LETTER_AXES = 5;
   localparam logic [7:0] USB_DEPTH = 8'h40;
   localparam logic [7:0] RS_DEPTH = 8'h80;
   localparam logic PORT_USB = 1'b0;
   localparam logic PORT_RS = 1'b1;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LAST_CMD = 8'h08;
   localparam logic [7:0] REG_AXIS_MASKS = 8'h0C;
   localparam logic [7:0] REG_VAL_SEL = 8'h10;
   localparam logic [7:0] REG_VAL = 8'h14;
   localparam logic [7:0] REG_CMD_COUNT = 8'h18;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // characters
   localparam logic [7:0] CH_SEMI = 8'h3B;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_QUERY = 8'h3F;
   localparam logic [7:0] CH_EQ = 8'h3D;
   localparam logic [7:0] CH_COLON = 8'h3A;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_H = 8'h48;
   localparam logic [7:0] CH_S = 8'h53;
   localparam logic [7:0] CH_T = 8'h54;
   localparam logic [7:0] CH_W = 8'h57;
   localparam logic [7:0] CH_X = 8'h58;
   localparam logic [7:0] CH_Y = 8'h59;
   localparam logic [7:0] CH_Z = 8'h5A;
   localparam logic [7:0] MARK_BIT = 8'h80;
   localparam logic [7:0] BIN_FIRST = 8'h80;
   localparam logic [15:0] OUTFMT_OP = 16'h4357;
   localparam logic [31:0] FMT_MARK_ON = 32'h00000001;
   localparam logic [31:0] FMT_MARK_OFF = 32'h00000002;
   localparam logic [7:0] SIZE_0 = 8'h00;
   localparam logic [7:0] SIZE_1 = 8'h01;
   localparam logic [7:0] SIZE_2 = 8'h02;
   localparam logic [7:0] SIZE_4 = 8'h04;
   localparam logic [7:0] SIZE_6 = 8'h06;
   localparam logic [7:0] COORD_ON = 8'h01;
   localparam logic [7:0] AXES_ALL = 8'hFF;
   localparam logic [47:0] DEC_BASE = 48'h00000000000A;
   localparam logic [1:0] SYNC_WARM = 2'h3;

   typedef enum logic [2:0] {
      PS_IDLE = 3'b000, PS_OP2 = 3'b001, PS_ARGS = 3'b011, PS_SKIP = 3'b010,
      PS_BSIZE = 3'b110, PS_BCOORD = 3'b111, PS_BMASK = 3'b101, PS_BDATA = 3'b100
   } hcp_ps_t;
   typedef struct packed {
      logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
      logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
   } hcp_axi_req_t;
   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } hcp_axi_rsp_t;
   typedef struct packed {logic hs_en; logic drop; logic mark;} hcp_ctrl_t;
   typedef struct packed {
      logic [15:0] opcode; logic binary; logic valid; logic from_prog; logic port;
      logic [1:0] planes; logic [7:0] set_mask; logic [7:0] query_mask;
      logic [7:0] act_mask; logic [7:0] size;
   } hcp_cmd_t;
   typedef struct packed {
      hcp_ctrl_t ctrl; logic [2:0] sync; logic [1:0] warm; logic caught; logic default_port;
      hcp_ps_t ps; logic [15:0] op; logic bad; logic space_used; logic had_arg;
      logic [2:0] fidx; logic fhas; logic fquery; logic fneg; logic [47:0] acc;
      logic [2:0] last_axis; logic last_letter; logic [7:0] bsize; logic [7:0] brem;
      logic [2:0] bcnt; logic [7:0][31:0] axis_val; hcp_cmd_t work; hcp_cmd_t cmd;
      logic cmd_pulse; logic [31:0] cmd_count; logic resp_pend; logic resp_port;
      logic [7:0] resp_char; logic [1:0][127:0][7:0] mem; logic [1:0][7:0] rd;
      logic [1:0][7:0] cnt; logic [1:0] tx_valid; logic [1:0][7:0] tx_data;
      logic in_ready; logic msg_ready; logic [7:0] last_gen; logic last_gen_port;
      logic aw_held; logic [7:0] aw_addr; logic w_held; logic [31:0] wdata;
      logic [3:0] wstrb; hcp_axi_rsp_t rsp; logic [2:0] sel;
   } hcp_state_t;
endpackage : hcp_pkg
`default_nettype wire
